/* fxr_pkg.sv */
// fxr_pkg: shared constants and types of the fp exception reporting block
// assumes a 32-bit apb register space with an 8-bit byte address

package fxr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NEXC  = 6;
  localparam int NFLAG = 7;
  localparam int NIRQ  = 3;
  localparam int AW    = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STAT     = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;

  // ----------------------------------------------------------------
  // exception class bit positions (flags and masks share them)
  // ----------------------------------------------------------------
  localparam int EXC_INV  = 0;
  localparam int EXC_DEN  = 1;
  localparam int EXC_ZDIV = 2;
  localparam int EXC_OVF  = 3;
  localparam int EXC_UNF  = 4;
  localparam int EXC_PREC = 5;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_MASK_LSB = 0;
  localparam int          CTRL_RND_LSB  = 8;
  localparam int          CTRL_NATIVE_BIT = 12;
  localparam int          CTRL_DEFER    = 13;
  localparam logic [31:0] CTRL_RST      = 32'h0000003f;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000333f;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_STACK_FAULT_BIT = 6;
  localparam int STAT_PEND_BIT = 7;
  localparam int STAT_FRZ_BIT  = 8;
  localparam int STAT_ERR_BIT  = 9;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int IRQ_UNM = 0;
  localparam int IRQ_FRZ = 1;
  localparam int IRQ_REL = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FXR_RND_NEAR,
    FXR_RND_CHOP,
    FXR_RND_UP,
    FXR_RND_DOWN
  } fxr_rnd_t;

  typedef enum logic [1:0] {
    FXR_OP_CLEAR,
    FXR_OP_REINIT,
    FXR_OP_SAVE,
    FXR_OP_RESTORE
  } fxr_op_t;

  typedef enum logic {
    FXR_RUN,
    FXR_FROZEN
  } fxr_state_t;

endpackage : fxr_pkg

/* fxr_flag_if.sv */
// fxr_flag_if: carries set, clear and load requests to the sticky flags
// assumes one clock domain shared by owner and user

`timescale 1ns/1ps

interface fxr_flag_if #(parameter int N = 7);
  logic [N-1:0] set;
  logic         clr;
  logic         load;
  logic [N-1:0] load_val;
  logic [N-1:0] flags;

  modport owner (output flags, input set, clr, load, load_val);
  modport user  (input flags, output set, clr, load, load_val);
endinterface : fxr_flag_if

/* fxr_flags.sv */
// fxr_flags: sticky, cumulative exception flag bank
// assumes set pulses are one cycle; set wins over clear and load

`timescale 1ns/1ps

module fxr_flags #(
  parameter int N = 7
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // flag requests
  fxr_flag_if.owner f
);

  logic [N-1:0] flags;
  logic [N-1:0] next_flags;

  always_comb
  begin
    next_flags = flags;
    if (f.clr)
    begin
      next_flags = '0;
    end
    if (f.load)
    begin
      next_flags = f.load_val;
    end
    next_flags = next_flags | f.set;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flags <= '0;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  assign f.flags = flags;

endmodule : fxr_flags

/* fxr_irq.sv */
// fxr_irq: sticky interrupt status, write-one-to-clear, with mask
// assumes event bits are one-cycle pulses; event wins over clear

`timescale 1ns/1ps

module fxr_irq #(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // events and register writes
  input  wire logic [N-1:0] event_i,
  input  wire logic         wr_stat_i,
  input  wire logic         wr_mask_i,
  input  wire logic [N-1:0] wdata_i,
  // state
  output logic      [N-1:0] stat_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);

  logic [N-1:0] next_stat;
  logic [N-1:0] next_mask;
  logic         next_irq;

  always_comb
  begin
    next_stat = stat_o;
    next_mask = mask_o;
    if (wr_stat_i)
    begin
      next_stat = stat_o & ~wdata_i;
    end
    if (wr_mask_i)
    begin
      next_mask = wdata_i;
    end
    next_stat = next_stat | event_i;
    next_irq  = |(next_stat & next_mask);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_o <= '0;
      mask_o <= '0;
      irq_o  <= 1'b0;
    end
    else
    begin
      stat_o <= next_stat;
      mask_o <= next_mask;
      irq_o  <= next_irq;
    end
  end

endmodule : fxr_irq

/* fxr_top.sv */
// fxr_top: fp exception detection, masking and external error reporting
// assumes datapath, decode and op strobes are synchronous to mclk_i
//
// How it works
// - detect six classes, invalid with stack-fault subcase
// - each class has flag and mask; masked fixes up
// - masked exception sets flag, nothing else shown
// - one instruction may raise several flags
// - masked underflow stores denormal or zero
// - four selectable rounding modes
// - flags sticky; cleared only by clear/reinit/save/restore
// - unmasked exception aborts instruction toward handler
// - legacy error asserts on detect or next fp/wait
// - pending error freezes before next waiting fp/wait
// - frozen until an external interrupt arrives
// - legacy mode with ignore input never freezes
// - coprocessor variant drives a dedicated error line
// - waiting fp instruction with flags pending re-raises
// - later generations report errors at the next waiting fp/wait instruction
// - packed single-precision exceptions never drive error

`timescale 1ns/1ps

module fxr_top (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [fxr_pkg::AW-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // datapath exception detection
  input  wire logic                  exc_valid_i,
  input  wire logic [fxr_pkg::NEXC-1:0] exc_i,
  input  wire logic                  stack_fault_i,
  input  wire logic                  below_min_i,
  // instruction stream
  input  wire logic                  instr_valid_i,
  input  wire logic                  instr_fp_i,
  input  wire logic                  instr_wait_i,
  input  wire logic                  instr_nowait_i,
  // flag operations
  input  wire logic                  op_valid_i,
  input  wire fxr_pkg::fxr_op_t      op_i,
  input  wire logic [fxr_pkg::NFLAG-1:0] op_data_i,
  // system pins
  input  wire logic                  ignore_numeric_error_in_i,
  input  wire logic                  maskable_irq_in_i,
  // reporting and fix-up
  output logic                       fpu_error_out_o,
  output logic                       coproc_error_o,
  output logic                       freeze_o,
  output logic                       abort_o,
  output logic                       native_exc_o,
  output logic      [fxr_pkg::NEXC-1:0] fixup_o,
  output logic                       denorm_store_o,
  output logic                       zero_store_o,
  output fxr_pkg::fxr_rnd_t          round_mode_o,
  output logic                       irq_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic fxr_hit(input logic [fxr_pkg::AW-1:0] a);
    fxr_hit = (a == fxr_pkg::OFF_CTRL) || (a == fxr_pkg::OFF_STAT) ||
              (a == fxr_pkg::OFF_IRQ_STAT) || (a == fxr_pkg::OFF_IRQ_MASK);
  endfunction : fxr_hit

  fxr_flag_if #(.N(fxr_pkg::NFLAG)) flg ();

  logic [31:0]              ctrl;
  logic [31:0]              next_ctrl;
  logic [fxr_pkg::NEXC-1:0] mask;
  logic                     native_error_enable;
  logic                     defer;
  logic [fxr_pkg::NEXC-1:0] exc_seen;
  logic [fxr_pkg::NEXC-1:0] unm_now;
  logic                     pending;
  logic                     fp_seen;
  logic                     blocking;
  logic                     ignore_eff;
  logic                     access;
  logic                     wr_en;
  logic [fxr_pkg::NIRQ-1:0] irq_ev;
  logic [fxr_pkg::NIRQ-1:0] irq_stat;
  logic [fxr_pkg::NIRQ-1:0] irq_mask;
  fxr_pkg::fxr_state_t      state;
  fxr_pkg::fxr_state_t      next_state;
  logic                     armed;
  logic                     next_armed;
  logic                     next_native;
  logic [31:0]              next_rdata;
  logic                     next_ready;
  logic                     next_err;

  assign mask       = ctrl[fxr_pkg::CTRL_MASK_LSB +: fxr_pkg::NEXC];
  assign native_error_enable = ctrl[fxr_pkg::CTRL_NATIVE_BIT];
  assign defer      = ctrl[fxr_pkg::CTRL_DEFER];
  assign exc_seen   = exc_valid_i ? exc_i : '0;
  assign unm_now    = exc_seen & ~mask;
  assign pending    = |(flg.flags[fxr_pkg::NEXC-1:0] & ~mask);
  assign fp_seen    = instr_valid_i & (instr_fp_i | instr_wait_i);
  assign blocking   = fp_seen & ~instr_nowait_i;
  assign ignore_eff = ~native_error_enable &
                      ignore_numeric_error_in_i;
  assign access     = psel_i & penable_i;
  assign wr_en      = access & pready_o & pwrite_i;

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  always_comb
  begin
    flg.set      = '0;
    flg.set[fxr_pkg::NEXC-1:0] = exc_seen;
    flg.set[fxr_pkg::STAT_STACK_FAULT_BIT] = exc_seen[fxr_pkg::EXC_INV] &
                                             stack_fault_i;
    flg.clr      = op_valid_i && (op_i != fxr_pkg::FXR_OP_RESTORE);
    flg.load     = op_valid_i && (op_i == fxr_pkg::FXR_OP_RESTORE);
    flg.load_val = op_data_i;
  end

  fxr_flags #(.N(fxr_pkg::NFLAG)) u_flags (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .f      (flg.owner)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_en && (paddr_i == fxr_pkg::OFF_CTRL))
    begin
      next_ctrl = pwdata_i & fxr_pkg::CTRL_WMASK;
    end
    if (op_valid_i && (op_i == fxr_pkg::FXR_OP_REINIT ||
                       op_i == fxr_pkg::FXR_OP_SAVE))
    begin
      next_ctrl = fxr_pkg::CTRL_RST;
    end
  end

  // ----------------------------------------------------------------
  // freeze, error and re-raise
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state  = state;
    next_native = 1'b0;
    unique case (state)
      fxr_pkg::FXR_RUN:
      begin
        if (pending && blocking)
        begin
          if (native_error_enable)
          begin
            next_native = 1'b1;
          end
          else if (!ignore_eff)
          begin
            next_state = fxr_pkg::FXR_FROZEN;
          end
        end
      end
      fxr_pkg::FXR_FROZEN:
      begin
        if (maskable_irq_in_i)
        begin
          next_state = fxr_pkg::FXR_RUN;
        end
      end
    endcase
    // only the scalar flag bank feeds the error pin
    next_armed = ~native_error_enable & pending &
                 (armed | fp_seen | ~defer);
    irq_ev     = '0;
    irq_ev[fxr_pkg::IRQ_UNM] = |unm_now;
    irq_ev[fxr_pkg::IRQ_FRZ] = (state == fxr_pkg::FXR_RUN) &&
                               (next_state == fxr_pkg::FXR_FROZEN);
    irq_ev[fxr_pkg::IRQ_REL] = (state == fxr_pkg::FXR_FROZEN) &&
                               (next_state == fxr_pkg::FXR_RUN);
  end

  fxr_irq #(.N(fxr_pkg::NIRQ)) u_irq (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .event_i   (irq_ev),
    .wr_stat_i (wr_en && (paddr_i == fxr_pkg::OFF_IRQ_STAT)),
    .wr_mask_i (wr_en && (paddr_i == fxr_pkg::OFF_IRQ_MASK)),
    .wdata_i   (pwdata_i[fxr_pkg::NIRQ-1:0]),
    .stat_o    (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ready = access & ~pready_o;
    next_err   = access & ~pready_o & ~fxr_hit(paddr_i);
    next_rdata = '0;
    unique case (paddr_i)
      fxr_pkg::OFF_CTRL:     next_rdata = ctrl;
      fxr_pkg::OFF_STAT:
      begin
        next_rdata[fxr_pkg::NFLAG-1:0]       = flg.flags;
        next_rdata[fxr_pkg::STAT_PEND_BIT]   = pending;
        next_rdata[fxr_pkg::STAT_FRZ_BIT]    = state == fxr_pkg::FXR_FROZEN;
        next_rdata[fxr_pkg::STAT_ERR_BIT]    = fpu_error_out_o;
      end
      fxr_pkg::OFF_IRQ_STAT: next_rdata[fxr_pkg::NIRQ-1:0] = irq_stat;
      fxr_pkg::OFF_IRQ_MASK: next_rdata[fxr_pkg::NIRQ-1:0] = irq_mask;
      default:               next_rdata = '0;
    endcase
    if (!next_ready || pwrite_i)
    begin
      next_rdata = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl            <= fxr_pkg::CTRL_RST;
      state           <= fxr_pkg::FXR_RUN;
      armed           <= 1'b0;
      fpu_error_out_o <= 1'b0;
      coproc_error_o  <= 1'b0;
      freeze_o        <= 1'b0;
      abort_o         <= 1'b0;
      native_exc_o    <= 1'b0;
      fixup_o         <= '0;
      denorm_store_o  <= 1'b0;
      zero_store_o    <= 1'b0;
      round_mode_o    <= fxr_pkg::FXR_RND_NEAR;
      prdata_o        <= '0;
      pready_o        <= 1'b0;
      pslverr_o       <= 1'b0;
    end
    else
    begin
      ctrl            <= next_ctrl;
      state           <= next_state;
      armed           <= next_armed;
      fpu_error_out_o <= next_armed;
      coproc_error_o  <= pending;
      freeze_o        <= next_state == fxr_pkg::FXR_FROZEN;
      abort_o         <= |unm_now;
      native_exc_o    <= next_native;
      fixup_o         <= exc_seen & mask;
      denorm_store_o  <= exc_seen[fxr_pkg::EXC_UNF] &
                         mask[fxr_pkg::EXC_UNF] & ~below_min_i;
      zero_store_o    <= exc_seen[fxr_pkg::EXC_UNF] &
                         mask[fxr_pkg::EXC_UNF] & below_min_i;
      round_mode_o    <= fxr_pkg::fxr_rnd_t'(
                         next_ctrl[fxr_pkg::CTRL_RND_LSB +: 2]);
      prdata_o        <= next_rdata;
      pready_o        <= next_ready;
      pslverr_o       <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_freeze_entry: assert property (
    (state == fxr_pkg::FXR_RUN) && pending && blocking &&
    !native_error_enable && !ignore_eff |=> freeze_o)
    else $error("no freeze on pending error");
  a_freeze_hold: assert property (
    freeze_o && !maskable_irq_in_i |=> freeze_o)
    else $error("freeze dropped without interrupt");
  a_freeze_release: assert property (
    freeze_o && maskable_irq_in_i |=> !freeze_o)
    else $error("freeze kept after interrupt");
  a_ignore_nofrz: assert property (
    !freeze_o && ignore_eff |=> !freeze_o)
    else $error("froze while ignore input active");
  a_abort_unmask: assert property (
    exc_valid_i && |(exc_i & ~mask) |=> abort_o)
    else $error("unmasked exception not aborted");
  a_masked_quiet: assert property (
    exc_valid_i && (exc_i & ~mask) == '0 |=>
    !abort_o ##0 fixup_o == $past(exc_i))
    else $error("masked exception gave indication");
  a_flags_sticky: assert property (
    !flg.clr && !flg.load |=>
    (flg.flags & $past(flg.flags)) == $past(flg.flags))
    else $error("flag lost without clearing op");
  a_multi_flags: assert property (
    exc_valid_i && !flg.clr && !flg.load |=>
    (flg.flags[fxr_pkg::NEXC-1:0] & $past(exc_i)) == $past(exc_i))
    else $error("exception flag not recorded");
  a_err_immed: assert property (
    !native_error_enable && !defer && pending |=> fpu_error_out_o)
    else $error("immediate error not asserted");
  a_err_defer: assert property (
    !native_error_enable && pending && fp_seen |=> fpu_error_out_o)
    else $error("error not asserted at next fp op");
  a_err_drop: assert property (
    !pending |=> !fpu_error_out_o)
    else $error("error asserted with no pending flag");
  a_reraise: assert property (
    (state == fxr_pkg::FXR_RUN) && native_error_enable && pending &&
    blocking |=> native_exc_o)
    else $error("pending flags did not re-raise");
  a_denorm_store: assert property (
    exc_valid_i && exc_i[fxr_pkg::EXC_UNF] && mask[fxr_pkg::EXC_UNF] |=>
    denorm_store_o != zero_store_o)
    else $error("masked underflow store not chosen");
  a_coproc_line: assert property (
    pending |=> coproc_error_o)
    else $error("coprocessor error line not driven");

  c_freeze_cycle: cover property (freeze_o ##[1:20] !freeze_o);
  c_reraise: cover property (native_exc_o ##[1:20] native_exc_o);
  c_deferred: cover property (defer && pending && !fpu_error_out_o
    ##[1:20] fpu_error_out_o);

endmodule : fxr_top

/* fxr_pic_model.sv */
// fxr_pic_model: outside logic turning the error pin into a cpu interrupt
// assumes error pin is a level on mclk_i; latch is cleared by a port write

`timescale 1ns/1ps

module fxr_pic_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // error pin, line enable, latch clear, other source
  input  wire logic err_i,
  input  wire logic enable_i,
  input  wire logic latch_clr_i,
  input  wire logic other_i,
  // request toward the cpu
  output logic      irq_o
);
  logic err_d;
  logic latch;
  int   cnt;

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_d <= 1'b0;
      latch <= 1'b0;
      cnt   <= 0;
      irq_o <= 1'b0;
    end
    else
    begin
      err_d <= err_i;
      if (latch_clr_i)
        latch <= 1'b0;
      else if (err_i && !err_d)
        latch <= 1'b1;
      cnt   <= latch ? cnt + 1 : 0;
      irq_o <= (latch && enable_i && cnt >= DLY) || other_i;
    end
  end
endmodule : fxr_pic_model

/* test_fpu_exception_reporting.sv */
// test_fpu_exception_reporting: self-checking bench for fxr_top
// assumes fxr_pkg, fxr_flag_if, fxr_flags, fxr_irq, fxr_top, fxr_pic_model

`timescale 1ns/1ps

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  mismatches++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end

module test_fpu_exception_reporting;
  logic        mclk_i = 1'b0, rst_i = 1'b1;
  logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, perr;
  logic        exc_valid_i = 0, stack_fault_i = 0, below_min_i = 0;
  logic [5:0]  exc_i = 6'h00, fixup_o, m_mask = 6'h3f;
  logic        instr_valid_i = 0, instr_fp_i = 0, instr_wait_i = 0;
  logic        instr_nowait_i = 0, op_valid_i = 0;
  fxr_pkg::fxr_op_t  op_i = fxr_pkg::FXR_OP_CLEAR;
  fxr_pkg::fxr_rnd_t round_mode_o;
  logic [6:0]  op_data_i = 7'h00, m_flags = 7'h00;
  logic        ignore_numeric_error_in_i = 0, maskable_irq_in_i;
  logic        fpu_error_out_o, coproc_error_o, freeze_o, abort_o;
  logic        native_exc_o, denorm_store_o, zero_store_o, irq_o;
  logic        pic_en = 0, latch_clr = 0, other_irq = 0;
  int          mismatches = 0, samples_checked = 0, cyc = 0, n;

  fxr_top dut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .exc_valid_i, .exc_i,
    .stack_fault_i, .below_min_i, .instr_valid_i, .instr_fp_i,
    .instr_wait_i, .instr_nowait_i, .op_valid_i, .op_i, .op_data_i,
    .ignore_numeric_error_in_i, .maskable_irq_in_i, .fpu_error_out_o,
    .coproc_error_o, .freeze_o, .abort_o, .native_exc_o, .fixup_o,
    .denorm_store_o, .zero_store_o, .round_mode_o, .irq_o);

  fxr_pic_model #(.DLY(3)) pic (.mclk_i, .rst_i, .err_i(fpu_error_out_o),
    .enable_i(pic_en), .latch_clr_i(latch_clr), .other_i(other_irq),
    .irq_o(maskable_irq_in_i));

  always #2.5 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  task automatic wctrl(input logic [31:0] v);
    apb(1'b1, fxr_pkg::OFF_CTRL, v);
    m_mask = v[5:0];
  endtask : wctrl

  task automatic exc(input logic [5:0] v, input logic sf, input logic bm);
    @(posedge mclk_i);
    exc_valid_i <= 1'b1;
    exc_i <= v;
    stack_fault_i <= sf;
    below_min_i <= bm;
    @(posedge mclk_i);
    exc_valid_i <= 1'b0;
    #1;
    m_flags = m_flags | {sf & v[0], v};
    `CHK(fixup_o, v & m_mask)
    `CHK(abort_o, |(v & ~m_mask))
    `CHK(denorm_store_o, v[4] & m_mask[4] & ~bm)
    `CHK(zero_store_o, v[4] & m_mask[4] & bm)
  endtask : exc

  task automatic instr(input logic fp, input logic nw);
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_fp_i <= fp;
    instr_wait_i <= ~fp;
    instr_nowait_i <= nw;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : instr

  task automatic op(input fxr_pkg::fxr_op_t o, input logic [6:0] d);
    @(posedge mclk_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    op_data_i <= d;
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
    m_flags = (o == fxr_pkg::FXR_OP_RESTORE) ? d : 7'h00;
    if (o == fxr_pkg::FXR_OP_REINIT || o == fxr_pkg::FXR_OP_SAVE)
      m_mask = 6'h3f;
  endtask : op

  task automatic released();
    n = 0;
    while (maskable_irq_in_i !== 1'b1 && n < 50)
    begin
      @(posedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    #1;
  endtask : released

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(26));
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(fxr_pkg::OFF_CTRL, 32'h3f);
    apb(1'b1, fxr_pkg::OFF_STAT, 32'hffffffff);
    rchk(fxr_pkg::OFF_STAT, 32'h0);
    apb(1'b1, 8'h10, 32'hffffffff);
    `CHK(perr, 1'b1)
    apb(1'b1, fxr_pkg::OFF_IRQ_MASK, 32'h7);
    for (int r = 0; r < 4; r++)
    begin
      wctrl(32'h3f | (r << 8));
      @(posedge mclk_i);
      #1;
      `CHK(round_mode_o, fxr_pkg::fxr_rnd_t'(r))
    end
    exc(6'h12, 1'b0, 1'b1);
    for (int k = 0; k < 12; k++)
      exc(6'($urandom), 1'($urandom), 1'($urandom));
    `CHK(fpu_error_out_o, 1'b0)
    rchk(fxr_pkg::OFF_STAT, {25'h0, m_flags});
    for (int k = 0; k < 4; k++)
    begin
      wctrl(32'h13f);
      exc(6'h3f, 1'b1, 1'b0);
      op(fxr_pkg::fxr_op_t'(k), 7'($urandom));
      rchk(fxr_pkg::OFF_STAT, {25'h0, m_flags});
      rchk(fxr_pkg::OFF_CTRL,
        (k == 1 || k == 2) ? fxr_pkg::CTRL_RST : 32'h13f);
    end
    op(fxr_pkg::FXR_OP_CLEAR, 7'h00);
    wctrl(32'h3e);
    exc(6'h01, 1'b1, 1'b0);
    @(posedge mclk_i);
    #1;
    `CHK(fpu_error_out_o, 1'b1)
    `CHK(coproc_error_o, 1'b1)
    instr(1'b1, 1'b1);
    `CHK(freeze_o, 1'b0)
    @(posedge mclk_i);
    ignore_numeric_error_in_i <= 1'b1;
    instr(1'b1, 1'b0);
    `CHK(freeze_o, 1'b0)
    @(posedge mclk_i);
    ignore_numeric_error_in_i <= 1'b0;
    instr(1'b0, 1'b0);
    `CHK(freeze_o, 1'b1)
    repeat (6) @(posedge mclk_i);
    #1;
    `CHK(freeze_o, 1'b1)
    @(posedge mclk_i);
    pic_en <= 1'b1;
    released();
    `CHK(freeze_o, 1'b0)
    @(posedge mclk_i);
    latch_clr <= 1'b1;
    @(posedge mclk_i);
    latch_clr <= 1'b0;
    pic_en <= 1'b0;
    repeat (2) @(posedge mclk_i);
    instr(1'b1, 1'b0);
    `CHK(freeze_o, 1'b1)
    repeat (4) @(posedge mclk_i);
    other_irq <= 1'b1;
    released();
    `CHK(freeze_o, 1'b0)
    @(posedge mclk_i);
    other_irq <= 1'b0;
    op(fxr_pkg::FXR_OP_CLEAR, 7'h00);
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(fpu_error_out_o, 1'b0)
    `CHK(coproc_error_o, 1'b0)
    wctrl(32'h203e);
    exc(6'h01, 1'b0, 1'b0);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK(fpu_error_out_o, 1'b0)
    instr(1'b1, 1'b1);
    `CHK(fpu_error_out_o, 1'b1)
    op(fxr_pkg::FXR_OP_CLEAR, 7'h00);
    wctrl(32'h103e);
    exc(6'h01, 1'b0, 1'b0);
    instr(1'b1, 1'b0);
    `CHK(native_exc_o, 1'b1)
    `CHK(freeze_o, 1'b0)
    `CHK(fpu_error_out_o, 1'b0)
    op(fxr_pkg::FXR_OP_CLEAR, 7'h00);
    rchk(fxr_pkg::OFF_IRQ_STAT, 32'h7);
    apb(1'b1, fxr_pkg::OFF_IRQ_MASK, 32'h0);
    #1;
    `CHK(irq_o, 1'b0)
    apb(1'b1, fxr_pkg::OFF_IRQ_MASK, 32'h7);
    #1;
    `CHK(irq_o, 1'b1)
    apb(1'b1, fxr_pkg::OFF_IRQ_STAT, 32'h1);
    rchk(fxr_pkg::OFF_IRQ_STAT, 32'h6);
    apb(1'b1, fxr_pkg::OFF_IRQ_STAT, 32'h6);
    @(posedge mclk_i);
    #1;
    `CHK(irq_o, 1'b0)
    close_out();
  end
endmodule : test_fpu_exception_reporting
